/* File: tpr_status_regs.sv */
/*
 * tpr_status_regs: pma link health, error power readout and the pcs
 * control/status registers of a single-pair 10 Mb/s phy.
 * assumes a frame engine on clk_sys presents one-cycle rd/wr strobes with
 * device address and register address; health inputs come from other
 * clock domains and are synchronised here.
 */
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// How it works
// [RULE1] any read of the link health register releases all held-low flags
// [RULE2] bit 9 holds far receiver ok low until read
// [RULE3] bit 7 holds near receiver ok low, bit 6 shows it live
// [RULE4] bit 5 holds descrambler ok low, bit 4 shows it live
// [RULE5] bit 1 holds link up low, bit 0 live; both reset to 0
// [RULE6] live far receiver ok is reported, placed at bit 8
// [RULE7] 16-bit read-only error power reading, reset zero, lsb 2^-18
// [RULE8] host forms snr as 0.64422 divided by the error reading
// [RULE9] pcs soft reset self clears and mirrors the pma soft reset
// [RULE10] pcs control bit 14 loops transmit data back to receive
// [RULE11] pcs control bit 11 is power down mirroring pma power down
// [RULE12] pcs status one reads 0x0002, power down capable
// [RULE13] devices present low reads 0x008b
// [RULE14] devices present high reads 0xc000
// [RULE15] pcs status two reads 0x8000, pcs exists
// [RULE16] single-pair pcs control bit 14 enables loopback, reset 0
// [RULE17] a held flag at 0 means loss since the previous read
// [RULE18] pma loopback control loops back when 1, normal when 0
// [RULE19] reserved bits read zero and ignore writes
// [RULE20] after release a held flag tracks live then latches new loss
module tpr_status_regs
	import tpr_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire tpr_req_t req,
	output logic [15:0] rdata,
	output logic rvalid,
	input wire tpr_health_t health_async,
	input wire logic [15:0] error_power_async,
	input wire logic medium_layer_soft_reset,
	input wire logic medium_layer_power_down,
	input wire logic medium_layer_loopback_on,
	output logic coding_layer_soft_reset,
	output logic coding_layer_power_down,
	output logic coding_layer_loopback_on,
	output logic single_pair_loopback_on,
	output logic pcs_loopback_active,
	output logic pma_loopback_active
);

	////////////////////////////////////////////////////////////////////
	// two-stage synchronisers; stage one is read only by stage two
	tpr_health_t health_s1_reg;
	tpr_health_t health_s2_reg;
	logic [15:0] err_s1_reg;
	logic [15:0] err_s2_reg;
	logic [15:0] err_s1_cmp_reg;
	logic [2:0] pma_s1_reg;
	logic [2:0] pma_s2_reg;
	logic [15:0] error_power_reading_reg;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			health_s1_reg <= '0;
			health_s2_reg <= '0;
			pma_s1_reg <= 3'h0;
			pma_s2_reg <= 3'h0;
		end else begin
			health_s1_reg <= health_async;
			health_s2_reg <= health_s1_reg;
			pma_s1_reg <= {medium_layer_soft_reset, medium_layer_power_down,
				medium_layer_loopback_on};
			pma_s2_reg <= pma_s1_reg;
		end
	end

	// error word: a multibit value may tear on its way across; the
	// reading is only taken when two successive samples agree
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			err_s1_reg <= 16'h0000;
			err_s2_reg <= 16'h0000;
			error_power_reading_reg <= 16'h0000; // see [RULE7]
		end else begin
			err_s1_reg <= error_power_async;
			err_s2_reg <= err_s1_reg;
			if (err_s2_reg == err_s1_cmp_reg)
				error_power_reading_reg <= err_s2_reg; // see [RULE7]
		end
	end

	// previous settled sample, kept apart so a torn word is never taken
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			err_s1_cmp_reg <= 16'h0000;
		else
			err_s1_cmp_reg <= err_s2_reg;
	end

	////////////////////////////////////////////////////////////////////
	// address decode helper
	function automatic logic hit(input tpr_req_t r, input logic [4:0] d,
		input logic [15:0] a);
		hit = (r.dev == d) && (r.addr == a);
	endfunction

	logic rd_link_health;
	logic wr_control_one;
	logic wr_single_pair;
	assign rd_link_health = req.rd && hit(req, TPR_DEV_PMA,
		TPR_PMA_LINK_HEALTH);
	assign wr_control_one = req.wr && hit(req, TPR_DEV_PCS,
		TPR_PCS_CONTROL_ONE);
	assign wr_single_pair = req.wr && hit(req, TPR_DEV_PCS,
		TPR_SINGLE_PAIR_PCS_CONTROL);

	////////////////////////////////////////////////////////////////////
	// held-low flags: a loss clears the flag and it stays clear until a
	// read; the read shows the held value, then the flag reloads from live
	logic [3:0] held_reg;
	logic [3:0] held_next;
	logic [3:0] live_vec;
	assign live_vec = {health_s2_reg.far_receiver_ok,
		health_s2_reg.near_receiver_ok, health_s2_reg.descrambler_ok,
		health_s2_reg.link_up};

	always_comb begin
		held_next = held_reg & live_vec; // see [RULE17]
		if (rd_link_health)
			held_next = live_vec; // see [RULE1] see [RULE20]
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			held_reg <= TPR_HELD_RESET_VAL; // see [RULE5]
		else
			held_reg <= held_next; // see [RULE2]
	end

	////////////////////////////////////////////////////////////////////
	// pcs control one: soft reset self clears one cycle after it is set;
	// the pma copy of either control feeds the same effect
	logic soft_reset_reg;
	logic loopback_reg;
	logic power_down_reg;
	logic sp_loopback_reg;
	logic pma_pd_q_reg;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			soft_reset_reg <= 1'b0;
		else if (wr_control_one && req.wdata[TPR_CTL_SOFT_RESET_BIT])
			soft_reset_reg <= 1'b1; // see [RULE9]
		else
			soft_reset_reg <= 1'b0; // see [RULE9]
	end

	// a soft reset returns control bits to their reset values
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			loopback_reg <= TPR_CTL_RESET_VAL[TPR_CTL_LOOPBACK_BIT];
			power_down_reg <= TPR_CTL_RESET_VAL[TPR_CTL_POWER_DOWN_BIT];
			sp_loopback_reg <= TPR_CTL_RESET_VAL[TPR_SP_LOOPBACK_BIT];
			pma_pd_q_reg <= 1'b0;
		end else begin
			pma_pd_q_reg <= pma_s2_reg[1];
			if (soft_reset_reg || pma_s2_reg[2]) begin
				loopback_reg <= 1'b0; // see [RULE9]
				power_down_reg <= 1'b0;
				sp_loopback_reg <= 1'b0;
			end else begin
				if (wr_control_one) begin
					loopback_reg <= req.wdata[TPR_CTL_LOOPBACK_BIT]; // see [RULE10]
					power_down_reg <= req.wdata[TPR_CTL_POWER_DOWN_BIT]; // see [RULE11]
				end else if (pma_s2_reg[1] != pma_pd_q_reg) begin
					power_down_reg <= pma_s2_reg[1]; // see [RULE11]
				end
				if (wr_single_pair)
					sp_loopback_reg <= req.wdata[TPR_SP_LOOPBACK_BIT]; // see [RULE16]
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// read mux; unmapped addresses and reserved bits read zero
	logic [15:0] rd_value;
	always_comb begin
		rd_value = 16'h0000; // see [RULE19]
		if (req.dev == TPR_DEV_PMA) begin
			case (req.addr)
			TPR_PMA_LINK_HEALTH: begin
				rd_value[TPR_LH_FAR_HELD_BIT] = held_reg[3]; // see [RULE2]
				rd_value[TPR_LH_FAR_LIVE_BIT] = live_vec[3]; // see [RULE6]
				rd_value[TPR_LH_NEAR_HELD_BIT] = held_reg[2]; // see [RULE3]
				rd_value[TPR_LH_NEAR_LIVE_BIT] = live_vec[2]; // see [RULE3]
				rd_value[TPR_LH_DSCR_HELD_BIT] = held_reg[1]; // see [RULE4]
				rd_value[TPR_LH_DSCR_LIVE_BIT] = live_vec[1]; // see [RULE4]
				rd_value[TPR_LH_LINK_HELD_BIT] = held_reg[0]; // see [RULE5]
				rd_value[TPR_LH_LINK_LIVE_BIT] = live_vec[0]; // see [RULE5]
			end
			TPR_MEAN_SQUARE_ERROR: rd_value = error_power_reading_reg; // see [RULE7]
			default: rd_value = 16'h0000;
			endcase
		end else if (req.dev == TPR_DEV_PCS) begin
			case (req.addr)
			TPR_PCS_CONTROL_ONE: begin
				rd_value[TPR_CTL_SOFT_RESET_BIT] = soft_reset_reg;
				rd_value[TPR_CTL_LOOPBACK_BIT] = loopback_reg;
				rd_value[TPR_CTL_POWER_DOWN_BIT] = power_down_reg;
			end
			TPR_PCS_STATUS_ONE: rd_value = TPR_STATUS_ONE_VAL; // see [RULE12]
			TPR_PCS_DEVICES_PRESENT_LOW: rd_value = TPR_DEVS_LOW_VAL; // see [RULE13]
			TPR_PCS_DEVICES_PRESENT_HIGH: rd_value = TPR_DEVS_HIGH_VAL; // see [RULE14]
			TPR_PCS_STATUS_TWO: rd_value = TPR_STATUS_TWO_VAL; // see [RULE15]
			TPR_SINGLE_PAIR_PCS_CONTROL:
				rd_value[TPR_SP_LOOPBACK_BIT] = sp_loopback_reg; // see [RULE16]
			default: rd_value = 16'h0000;
			endcase
		end
	end

	// registered read answer, one cycle after the strobe
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rdata <= 16'h0000;
			rvalid <= 1'b0;
		end else begin
			rvalid <= req.rd;
			if (req.rd)
				rdata <= rd_value;
		end
	end

	////////////////////////////////////////////////////////////////////
	// control outputs, registered
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			coding_layer_soft_reset <= 1'b0;
			coding_layer_power_down <= 1'b0;
			coding_layer_loopback_on <= 1'b0;
			single_pair_loopback_on <= 1'b0;
			pcs_loopback_active <= 1'b0;
			pma_loopback_active <= 1'b0;
		end else begin
			coding_layer_soft_reset <= soft_reset_reg || pma_s2_reg[2]; // see [RULE9]
			coding_layer_power_down <= power_down_reg; // see [RULE11]
			coding_layer_loopback_on <= loopback_reg; // see [RULE10]
			single_pair_loopback_on <= sp_loopback_reg; // see [RULE16]
			pcs_loopback_active <= loopback_reg || sp_loopback_reg; // see [RULE10]
			pma_loopback_active <= pma_s2_reg[0]; // see [RULE18]
		end
	end

endmodule

/* File: tpr_pkg.sv */
/*
 * tpr_pkg: shared constants and carriers for the pma/pcs management bank.
 * assumes a 16-bit register space split by management device address.
 */
package tpr_pkg;
	// management device addresses
	localparam logic [4:0] TPR_DEV_PMA = 5'h01;
	localparam logic [4:0] TPR_DEV_PCS = 5'h03;
	// register offsets
	localparam logic [15:0] TPR_PCS_CONTROL_ONE = 16'h0000;
	localparam logic [15:0] TPR_PCS_STATUS_ONE = 16'h0001;
	localparam logic [15:0] TPR_PCS_DEVICES_PRESENT_LOW = 16'h0005;
	localparam logic [15:0] TPR_PCS_DEVICES_PRESENT_HIGH = 16'h0006;
	localparam logic [15:0] TPR_PCS_STATUS_TWO = 16'h0008;
	localparam logic [15:0] TPR_SINGLE_PAIR_PCS_CONTROL = 16'h08e6;
	localparam logic [15:0] TPR_PMA_LINK_HEALTH = 16'h8302;
	localparam logic [15:0] TPR_MEAN_SQUARE_ERROR = 16'h830b;
	// field positions
	localparam int TPR_CTL_SOFT_RESET_BIT = 15;
	localparam int TPR_CTL_LOOPBACK_BIT = 14;
	localparam int TPR_CTL_POWER_DOWN_BIT = 11;
	localparam int TPR_SP_LOOPBACK_BIT = 14;
	localparam int TPR_LH_FAR_HELD_BIT = 9;
	localparam int TPR_LH_FAR_LIVE_BIT = 8;
	localparam int TPR_LH_NEAR_HELD_BIT = 7;
	localparam int TPR_LH_NEAR_LIVE_BIT = 6;
	localparam int TPR_LH_DSCR_HELD_BIT = 5;
	localparam int TPR_LH_DSCR_LIVE_BIT = 4;
	localparam int TPR_LH_LINK_HELD_BIT = 1;
	localparam int TPR_LH_LINK_LIVE_BIT = 0;
	// constant read and reset values
	localparam logic [15:0] TPR_STATUS_ONE_VAL = 16'h0002;
	localparam logic [15:0] TPR_DEVS_LOW_VAL = 16'h008b;
	localparam logic [15:0] TPR_DEVS_HIGH_VAL = 16'hc000;
	localparam logic [15:0] TPR_STATUS_TWO_VAL = 16'h8000;
	localparam logic [15:0] TPR_CTL_RESET_VAL = 16'h0000;
	localparam logic [3:0] TPR_HELD_RESET_VAL = 4'h0;

	// live line conditions, one bit each
	typedef struct packed {
		logic far_receiver_ok;
		logic near_receiver_ok;
		logic descrambler_ok;
		logic link_up;
	} tpr_health_t;

	// management access request
	typedef struct packed {
		logic rd;
		logic wr;
		logic [4:0] dev;
		logic [15:0] addr;
		logic [15:0] wdata;
	} tpr_req_t;
endpackage

/* File: tpr_status_regs_asserts.sv */
/*
 * checker for the pma/pcs management bank ports.
 * assumes one clk_sys domain and one-cycle rd/wr strobes from the host.
 */
`timescale 1ns/1ps

module tpr_status_regs_asserts
	import tpr_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire tpr_req_t req,
	input wire logic [15:0] rdata,
	input wire logic rvalid,
	input wire logic coding_layer_soft_reset,
	input wire logic coding_layer_loopback_on,
	input wire logic single_pair_loopback_on,
	input wire logic pcs_loopback_active
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);

	////////////////////////////////////////////////////////////////////////
	// read of one register address on one device
	function automatic logic hit(tpr_req_t q, logic [4:0] d, logic [15:0] a);
		return q.rd && q.dev == d && q.addr == a;
	endfunction

	read_answer_a:
		assert property (req.rd |=> rvalid)
		else $error("no answer");
	no_stray_a:
		assert property (rvalid |-> $past(req.rd))
		else $error("stray answer");
	data_hold_a:
		assert property (!$past(req.rd) |-> $stable(rdata))
		else $error("rdata moved");
	status_one_a:
		assert property (hit(req, TPR_DEV_PCS, 16'h0001) |=>
			rdata == 16'h0002)
		else $error("status one");
	devs_low_a:
		assert property (hit(req, TPR_DEV_PCS, 16'h0005) |=>
			rdata == 16'h008b)
		else $error("devices low");
	devs_high_a:
		assert property (hit(req, TPR_DEV_PCS, 16'h0006) |=>
			rdata == 16'hc000)
		else $error("devices high");
	status_two_a:
		assert property (hit(req, TPR_DEV_PCS, 16'h0008) |=>
			rdata == 16'h8000)
		else $error("status two");
	health_rsvd_a:
		assert property (hit(req, TPR_DEV_PMA, 16'h8302) |=>
			rdata[15:10] == 6'h00 && rdata[3:2] == 2'h0)
		else $error("reserved set");
	reset_pulse_a:
		assert property (req.wr && req.dev == TPR_DEV_PCS &&
			req.addr == 16'h0000 && req.wdata[15] |=> ##1
			coding_layer_soft_reset)
		else $error("no soft reset");
	reset_clears_a:
		assert property (coding_layer_soft_reset |=>
			!coding_layer_loopback_on && !single_pair_loopback_on)
		else $error("loopback kept");
	loop_or_a:
		assert property (coding_layer_loopback_on ||
			single_pair_loopback_on |-> ##[0:1] pcs_loopback_active)
		else $error("loopback or");

	cover_held: cover property (hit(req, TPR_DEV_PMA, 16'h8302));
	cover_reset: cover property (coding_layer_soft_reset);
	cover_loop: cover property (pcs_loopback_active);
endmodule

bind tpr_status_regs tpr_status_regs_asserts chk (.clk_sys, .rst, .req,
	.rdata, .rvalid, .coding_layer_soft_reset, .coding_layer_loopback_on,
	.single_pair_loopback_on, .pcs_loopback_active);

/* File: tpr_host_model.sv */
/*
 * station management host model: issues one-cycle register accesses.
 * assumes its task is entered just after a falling edge of clk_sys.
 */
`timescale 1ns/1ps

module tpr_host_model
	import tpr_pkg::*;
(
	input wire logic clk_sys,
	output tpr_req_t req
);
	initial req = '0;

	// strobe held one full cycle so the rising edge samples it once;
	// one idle cycle follows so no two assignments share a time step
	task automatic xfer(input logic r, input logic w, input logic [4:0] d,
		input logic [15:0] a, input logic [15:0] wd);
		req = '{r, w, d, a, wd};
		@(negedge clk_sys);
		req = '0;
		@(negedge clk_sys);
	endtask
endmodule

/* File: tpr_status_regs_bench.sv */
/*
 * self-checking bench for the pma/pcs management bank.
 * assumes the host model drives req and all reads answer one cycle later.
 */
`timescale 1ns/1ps

module tpr_status_regs_bench
	import tpr_pkg::*;
;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	tpr_req_t req;
	logic [15:0] rdata, err, m;
	logic rvalid, msr, mpd, mlb, clso, clpd, cllb, splb, pla, pmla;
	tpr_health_t health;
	int fail_count, checked;
	int pos[4] = '{1, 5, 7, 9};
	logic [15:0] exp_q[$];
	logic [31:0] seed = 32'h00000034;

	always #50 clk_sys = ~clk_sys;

	tpr_host_model host (.clk_sys(clk_sys), .req(req));
	tpr_status_regs dut (.clk_sys(clk_sys), .rst(rst), .req(req),
		.rdata(rdata), .rvalid(rvalid), .health_async(health),
		.error_power_async(err), .medium_layer_soft_reset(msr),
		.medium_layer_power_down(mpd), .medium_layer_loopback_on(mlb),
		.coding_layer_soft_reset(clso), .coding_layer_power_down(clpd),
		.coding_layer_loopback_on(cllb), .single_pair_loopback_on(splb),
		.pcs_loopback_active(pla), .pma_loopback_active(pmla));

	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_sim();
		if (fail_count == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic rd_chk(input logic [4:0] d, input logic [15:0] a,
		input logic [15:0] e);
		exp_q.push_back(e);
		host.xfer(1'b1, 1'b0, d, a, 16'h0000);
	endtask

	task automatic wr(input logic [15:0] a, input logic [15:0] wd);
		host.xfer(1'b0, 1'b1, TPR_DEV_PCS, a, wd);
	endtask

	task automatic idle(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	////////////////////////////////////////////////////////////////////////
	// answers are compared with the oldest note, off the launching edge
	always @(negedge clk_sys) begin
		if (rvalid === 1'b1)
			check(rdata, exp_q.pop_front());
	end

	initial begin
		idle(3000);
		fail_count++;
		end_sim();
	end

	initial begin
		health = '1; err = 16'h0000; msr = 0; mpd = 0; mlb = 0;
		idle(16);
		rst = 0;
		idle(4);
		rd_chk(TPR_DEV_PCS, TPR_PCS_CONTROL_ONE, 16'h0000);
		rd_chk(TPR_DEV_PCS, TPR_PCS_STATUS_ONE, 16'h0002);
		rd_chk(TPR_DEV_PCS, TPR_PCS_DEVICES_PRESENT_LOW,
			16'h008b);
		rd_chk(TPR_DEV_PCS, TPR_PCS_DEVICES_PRESENT_HIGH,
			16'hc000);
		rd_chk(TPR_DEV_PCS, TPR_PCS_STATUS_TWO, 16'h8000);
		rd_chk(TPR_DEV_PCS, TPR_SINGLE_PAIR_PCS_CONTROL,
			16'h0000);
		rd_chk(TPR_DEV_PMA, TPR_MEAN_SQUARE_ERROR, 16'h0000);
		rd_chk(TPR_DEV_PMA, TPR_PMA_LINK_HEALTH, 16'h0151);
		rd_chk(TPR_DEV_PMA, TPR_PMA_LINK_HEALTH, 16'h03f3);
		// each condition lost, read while lost, then read after recovery
		for (int i = 0; i < 4; i++) begin
			m = 16'h1 << pos[i];
			health[i] = 1'b0;
			idle(4);
			rd_chk(TPR_DEV_PMA, TPR_PMA_LINK_HEALTH,
				16'h03f3 & ~(m | m >> 1));
			health[i] = 1'b1;
			idle(4);
			rd_chk(TPR_DEV_PMA, TPR_PMA_LINK_HEALTH,
				16'h03f3 & ~m);
			rd_chk(TPR_DEV_PMA, TPR_PMA_LINK_HEALTH, 16'h03f3);
		end
		// the host divides idle power 0.64422 by this word
		repeat (2) begin
			seed = xs(seed);
			err = seed[15:0];
			idle(6);
			rd_chk(TPR_DEV_PMA, TPR_MEAN_SQUARE_ERROR, err);
		end
		wr(TPR_PCS_CONTROL_ONE, 16'h7fff);
		wr(TPR_SINGLE_PAIR_PCS_CONTROL, 16'h7fff);
		wr(TPR_PCS_STATUS_ONE, 16'hffff);
		rd_chk(TPR_DEV_PCS, TPR_PCS_CONTROL_ONE, 16'h4800);
		rd_chk(TPR_DEV_PCS, TPR_SINGLE_PAIR_PCS_CONTROL,
			16'h4000);
		rd_chk(TPR_DEV_PCS, TPR_PCS_STATUS_ONE, 16'h0002);
		check({12'h000, cllb, splb, clpd, pla}, 16'h000f);
		wr(TPR_PCS_CONTROL_ONE, 16'h8000);
		idle(3);
		check({14'h0000, cllb, splb}, 16'h0000);
		rd_chk(TPR_DEV_PCS, TPR_PCS_CONTROL_ONE, 16'h0000);
		mpd = 1;
		idle(5);
		rd_chk(TPR_DEV_PCS, TPR_PCS_CONTROL_ONE, 16'h0800);
		mpd = 0;
		mlb = 1;
		idle(5);
		rd_chk(TPR_DEV_PCS, TPR_PCS_CONTROL_ONE, 16'h0000);
		check({15'h0000, pmla}, 16'h0001);
		wr(TPR_PCS_CONTROL_ONE, 16'h4000);
		msr = 1;
		idle(5);
		check({15'h0000, clso}, 16'h0001);
		msr = 0;
		idle(5);
		rd_chk(TPR_DEV_PCS, TPR_PCS_CONTROL_ONE, 16'h0000);
		rd_chk(5'h02, 16'h0000, 16'h0000);
		rd_chk(TPR_DEV_PMA, 16'h0001, 16'h0000);
		idle(4);
		end_sim();
	end
endmodule
